// *** hw/sfb_unit.v ***
`timescale 1ns/1ps
`include "sfb_consts.vh"
// Function
// [RQ1] Special functions finish in one cycle, one word, cache allowed.
// [RQ2] Optional condition from seventeen codes, each with its complement.
// [RQ3] Flags reflect the latest accumulator-producing operation.
// [RQ4] Counted form: bump counter one; on true execute and copy to two.
// [RQ5] Counted form: counter zero not bumped; counter one bumped once only.
// [RQ6] Right shifts 1/4/8/16 on 36 bits with sign fill.
// [RQ7] Left shifts on low 32 bits, guard bits from bit 31.
// [RQ8] Copy places source; negate places two's complement.
// [RQ9] Round to 16 bits, sign-extended high, low half zero.
// [RQ10] High-half increment adds 0x10000 and clears low half.
// [RQ11] Full increment adds one to the 36-bit source.
// [RQ12] Copy y or aligned product into destination accumulator.
// [RQ13] Nop takes one cycle, only program counter advances; the code also loads interrupt_return_reg with the new pointer.
// [RQ14] No delay slots: next instruction at the new pointer.
// [RQ15] Unconditional control two cycles, conditional three, trap call three.
// [RQ16] Control instructions refused while running from cache.
// [RQ17] Trap call and trap return always unconditional.
// [RQ18] Control conditions: flags, counter compares, random bit.
// [RQ19] Immediate jump loads low 12 bits, keeps upper 4, return untouched.
// [RQ20] Immediate call saves i+1 then loads low 12 bits; the code saves i+2 when the call is conditional.
// [RQ21] Jump through target register loads full 16 bits.
// [RQ22] Counters are 8-bit signed, read back sign-extended to 16.
// [RQ23] Pointer, target and return registers are 16-bit unsigned.
// [RQ24] Counters wrap modulo 256 with no flag.
// [RQ25] Special-function results update the condition flags.
module sfb_unit (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        sf_valid,
  input  wire [3:0]  sf_op,
  input  wire        sf_dst,
  input  wire        sf_src,
  input  wire        sf_cond_en,
  input  wire        sf_counted,
  input  wire        ct_valid,
  input  wire [2:0]  ct_op,
  input  wire        ct_cond_en,
  input  wire [11:0] jump_target_field,
  input  wire        in_cache,
  input  wire [4:0]  branch_predicate_field,
  input  wire        cond_invert,
  input  wire        alu_valid,
  input  wire        alu_dst,
  input  wire [35:0] alu_result,
  input  wire        alu_lvs,
  input  wire        alu_mvs,
  input  wire        tgt_load,
  input  wire [15:0] tgt_data,
  input  wire [31:0] y_val,
  input  wire [35:0] p_val,
  input  wire        seq_advance,
  output reg  [35:0] first_accumulator,
  output reg  [35:0] second_accumulator,
  output reg  [15:0] instruction_pointer,
  output reg  [15:0] subroutine_return_reg,
  output reg  [15:0] branch_target_reg,
  output reg  [15:0] interrupt_return_reg,
  output reg  [15:0] count_zero_reg,
  output reg  [15:0] count_one_reg,
  output reg  [15:0] count_two_reg,
  output reg         flag_n,
  output reg         flag_z,
  output reg         flag_lvs,
  output reg         flag_mvs,
  output reg         busy,
  output reg         ct_refused
);
  reg  [7:0]  cnt0;
  reg  [7:0]  cnt1;
  reg  [7:0]  cnt2;
  reg  [15:0] lfsr;
  reg  [1:0]  ct_state;
  reg  [2:0]  ct_op_q;
  reg  [11:0] jump_q;
  reg  [15:0] ret_q;
  reg         ct_taken_q;
  reg  [1:0]  next_ct_state;
  reg         cond_raw;
  reg         cond_true;
  reg  [35:0] sf_source;
  reg  [7:0]  next_cnt1;
  reg         sf_exec;
  wire [35:0] sf_result;
  wire [4:0]  cc;
  wire        ct_accept;
  wire        ct_uncond;

  // Sign-extend an 8-bit counter to 16 bits for readback
  function [15:0] sfb_sext8;
    input [7:0] v;
    begin
      sfb_sext8 = {{8{v[7]}}, v};
    end
  endfunction

  // Zero-flag test of an accumulator value
  function sfb_zero;
    input [35:0] v;
    begin
      sfb_zero = (v == `SFB_ACC_RST);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Datapath instance
  sfb_shifter u_shift (
    .op     (sf_op),
    .src    (sf_source),
    .y_val  (y_val),
    .p_val  (p_val),
    .result (sf_result)
  );

  assign cc = branch_predicate_field;
  // [RQ16] no control from cache
  assign ct_accept = ct_valid && !in_cache && (ct_state == `SFB_ST_IDLE);
  // [RQ17] trap call/return ignore condition
  assign ct_uncond = !ct_cond_en || (ct_op == `SFB_CT_ICALL) || (ct_op == `SFB_CT_IRETURN);

  ////////////////////////////////////////////////////////////////////////////
  // Condition evaluation
  always @*
  begin
    sf_source = sf_src ? second_accumulator : first_accumulator;
    // [RQ18] flags, counters, random bit
    case (cc)
      `SFB_CC_NEG:   cond_raw = flag_n;
      `SFB_CC_POS:   cond_raw = !flag_n;
      `SFB_CC_EQ:    cond_raw = flag_z;
      `SFB_CC_NE:    cond_raw = !flag_z;
      `SFB_CC_GT:    cond_raw = !flag_n && !flag_z;
      `SFB_CC_LE:    cond_raw = flag_n || flag_z;
      `SFB_CC_LVS:   cond_raw = flag_lvs;
      `SFB_CC_MVS:   cond_raw = flag_mvs;
      `SFB_CC_MVC:   cond_raw = !flag_mvs;
      `SFB_CC_C0GE:  cond_raw = !cnt0[7];
      `SFB_CC_C0LT:  cond_raw = cnt0[7];
      `SFB_CC_C1GE:  cond_raw = !cnt1[7];
      `SFB_CC_C1LT:  cond_raw = cnt1[7];
      `SFB_CC_HEADS: cond_raw = lfsr[0];
      `SFB_CC_TAILS: cond_raw = !lfsr[0];
      `SFB_CC_TRUE:  cond_raw = 1'b1;
      `SFB_CC_FALSE: cond_raw = 1'b0;
      default:       cond_raw = 1'b0;
    endcase
    // [RQ2] complement option
    cond_true = cond_raw ^ cond_invert;
    sf_exec = sf_valid && (!sf_cond_en || cond_true) && (sf_op != `SFB_SF_NOP);
    // [RQ5] single counter-one bump
    next_cnt1 = cnt1 + `SFB_CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control sequencer next state; long stall covers the extra cycles
  always @*
  begin
    next_ct_state = ct_state;
    case (ct_state)
      `SFB_ST_IDLE:
        // [RQ15] conditional adds a cycle
        if (ct_accept)
          next_ct_state = ct_uncond && (ct_op != `SFB_CT_ICALL) ? `SFB_ST_DONE : `SFB_ST_EXT;
      `SFB_ST_EXT:  if (seq_advance) next_ct_state = `SFB_ST_DONE;
      `SFB_ST_DONE: if (seq_advance) next_ct_state = `SFB_ST_IDLE;
      default:      next_ct_state = `SFB_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulators and flags
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_accumulator  <= `SFB_ACC_RST;
      second_accumulator <= `SFB_ACC_RST;
      flag_n             <= 1'b0;
      flag_z             <= 1'b1;
      flag_lvs           <= 1'b0;
      flag_mvs           <= 1'b0;
    end
    else if (sf_exec)
    begin
      // [RQ1] single-cycle write
      if (sf_dst)
        second_accumulator <= sf_result;
      else
        first_accumulator <= sf_result;
      // [RQ25] result sets flags
      flag_n   <= sf_result[35];
      flag_z   <= sfb_zero(sf_result);
      flag_lvs <= 1'b0;
      flag_mvs <= (sf_result[35:31] != {5{sf_result[31]}});
    end
    else if (alu_valid)
    begin
      // [RQ3] latest accumulator result
      if (alu_dst)
        second_accumulator <= alu_result;
      else
        first_accumulator <= alu_result;
      flag_n   <= alu_result[35];
      flag_z   <= sfb_zero(alu_result);
      flag_lvs <= alu_lvs;
      flag_mvs <= alu_mvs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event counters; counter zero is never advanced anywhere, only reset and read back
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt0           <= `SFB_CNT_RST;
      cnt1           <= `SFB_CNT_RST;
      cnt2           <= `SFB_CNT_RST;
      count_zero_reg <= 16'h0000;
      count_one_reg  <= 16'h0000;
      count_two_reg  <= 16'h0000;
    end
    else
    begin
      // [RQ4] counted form bumps counter one
      if (sf_valid && sf_counted)
      begin
        // [RQ24] plain 8-bit wrap
        cnt1 <= next_cnt1;
        count_one_reg <= sfb_sext8(next_cnt1);
        if (!sf_cond_en || cond_true)
        begin
          cnt2 <= next_cnt1;
          count_two_reg <= sfb_sext8(next_cnt1);
        end
      end
      // [RQ22] sign-extended readback
      count_zero_reg <= sfb_sext8(cnt0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Random bit source, free running
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      lfsr <= `SFB_LFSR_RST;
    else
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ `SFB_LFSR_TAP) : (lfsr >> 1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program flow registers
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ct_state              <= `SFB_ST_IDLE;
      ct_op_q               <= `SFB_CT_GOTO_IMM;
      jump_q                <= 12'h000;
      ret_q                 <= `SFB_PC_RST;
      ct_taken_q            <= 1'b0;
      instruction_pointer   <= `SFB_PC_RST;
      subroutine_return_reg <= `SFB_PC_RST;
      branch_target_reg     <= `SFB_PC_RST;
      interrupt_return_reg  <= `SFB_PC_RST;
      busy                  <= 1'b0;
      ct_refused            <= 1'b0;
    end
    else
    begin
      ct_state   <= next_ct_state;
      busy       <= (next_ct_state != `SFB_ST_IDLE);
      ct_refused <= ct_valid && in_cache;
      // [RQ23] 16-bit target register
      if (tgt_load)
        branch_target_reg <= tgt_data;
      if (ct_accept)
      begin
        ct_op_q    <= ct_op;
        jump_q     <= jump_target_field;
        ret_q      <= instruction_pointer + (ct_uncond ? `SFB_PC_ONE : 16'h0002);
        ct_taken_q <= ct_uncond || cond_true;
      end
      else if (ct_state == `SFB_ST_IDLE && !ct_valid && (sf_valid || alu_valid))
      begin
        // [RQ13] ordinary instruction advances pointer
        instruction_pointer  <= instruction_pointer + `SFB_PC_ONE;
        interrupt_return_reg <= instruction_pointer + `SFB_PC_ONE;
      end
      // [RQ14] new pointer set before next instruction
      if (ct_state == `SFB_ST_DONE && seq_advance)
      begin
        if (!ct_taken_q)
          instruction_pointer <= ret_q;
        else
          case (ct_op_q)
            // [RQ19] low 12 bits, keep top 4
            `SFB_CT_GOTO_IMM: instruction_pointer <= {instruction_pointer[15:12], jump_q};
            `SFB_CT_CALL_IMM:
            begin
              // [RQ20] save i+1 (i+2 if conditional) then jump
              subroutine_return_reg <= ret_q;
              instruction_pointer   <= {instruction_pointer[15:12], jump_q};
            end
            // [RQ21] full 16-bit target
            `SFB_CT_GOTO_TGT: instruction_pointer <= branch_target_reg;
            `SFB_CT_CALL_TGT:
            begin
              subroutine_return_reg <= ret_q;
              instruction_pointer   <= branch_target_reg;
            end
            `SFB_CT_ICALL:
            begin
              interrupt_return_reg <= ret_q;
              instruction_pointer  <= `SFB_ICALL_VEC;
            end
            `SFB_CT_RETURN:  instruction_pointer <= subroutine_return_reg;
            `SFB_CT_IRETURN: instruction_pointer <= interrupt_return_reg;
            default:         instruction_pointer <= ret_q;
          endcase
      end
    end
  end
endmodule // sfb_unit

// *** hw/sfb_consts.vh ***
`ifndef SFB_CONSTS_VH
`define SFB_CONSTS_VH
// Widths
`define SFB_ACC_W      36
`define SFB_PC_W       16
`define SFB_CNT_W      8
`define SFB_JT_W       12
// Special function codes
`define SFB_SF_SRA1    4'h0
`define SFB_SF_SRA4    4'h1
`define SFB_SF_SRA8    4'h2
`define SFB_SF_SRA16   4'h3
`define SFB_SF_SLL1    4'h4
`define SFB_SF_SLL4    4'h5
`define SFB_SF_SLL8    4'h6
`define SFB_SF_SLL16   4'h7
`define SFB_SF_COPY    4'h8
`define SFB_SF_NEG     4'h9
`define SFB_SF_RND     4'hA
`define SFB_SF_INCH    4'hB
`define SFB_SF_INC     4'hC
`define SFB_SF_Y       4'hD
`define SFB_SF_P       4'hE
`define SFB_SF_NOP     4'hF
// Control codes
`define SFB_CT_GOTO_IMM 3'h0
`define SFB_CT_CALL_IMM 3'h1
`define SFB_CT_GOTO_TGT 3'h2
`define SFB_CT_CALL_TGT 3'h3
`define SFB_CT_ICALL   3'h4
`define SFB_CT_RETURN  3'h5
`define SFB_CT_IRETURN 3'h6
// Condition codes
`define SFB_CC_NEG     5'h00
`define SFB_CC_POS     5'h01
`define SFB_CC_EQ      5'h02
`define SFB_CC_NE      5'h03
`define SFB_CC_GT      5'h04
`define SFB_CC_LE      5'h05
`define SFB_CC_LVS     5'h06
`define SFB_CC_MVS     5'h07
`define SFB_CC_MVC     5'h08
`define SFB_CC_C0GE    5'h09
`define SFB_CC_C0LT    5'h0A
`define SFB_CC_C1GE    5'h0B
`define SFB_CC_C1LT    5'h0C
`define SFB_CC_HEADS   5'h0D
`define SFB_CC_TAILS   5'h0E
`define SFB_CC_TRUE    5'h0F
`define SFB_CC_FALSE   5'h10
// Constants
`define SFB_INCH_VAL   36'h000010000
`define SFB_INC_VAL    36'h000000001
`define SFB_RND_VAL    36'h000008000
`define SFB_ICALL_VEC  16'h0002
`define SFB_PC_RST     16'h0000
`define SFB_ACC_RST    36'h000000000
`define SFB_CNT_RST    8'h00
`define SFB_LFSR_RST   16'hACE1
`define SFB_LFSR_TAP   16'hB400
`define SFB_CNT_ONE    8'h01
`define SFB_PC_ONE     16'h0001
// Control sequencer states
`define SFB_ST_IDLE    2'h0
`define SFB_ST_EXT     2'h1
`define SFB_ST_DONE    2'h2
`endif

// *** hw/sfb_shifter.v ***
`timescale 1ns/1ps
`include "sfb_consts.vh"
// Combinational special-function datapath; result is registered by the top.
module sfb_shifter (
  input  wire [3:0]  op,
  input  wire [35:0] src,
  input  wire [31:0] y_val,
  input  wire [35:0] p_val,
  output reg  [35:0] result
);
  reg [35:0] rnd_sum;
  reg [31:0] low_sh;

  ////////////////////////////////////////////////////////////////////////////
  // Operation select
  always @*
  begin
    rnd_sum = src + `SFB_RND_VAL;
    low_sh  = src[31:0];
    result  = src;
    case (op)
      // [RQ6] sign-filling right shift
      `SFB_SF_SRA1:  result = {{1{src[35]}}, src[35:1]};
      `SFB_SF_SRA4:  result = {{4{src[35]}}, src[35:4]};
      `SFB_SF_SRA8:  result = {{8{src[35]}}, src[35:8]};
      `SFB_SF_SRA16: result = {{16{src[35]}}, src[35:16]};
      // [RQ7] left shift, guard from 31
      `SFB_SF_SLL1:
      begin
        low_sh = {src[30:0], 1'b0};
        result = {{4{low_sh[31]}}, low_sh};
      end
      `SFB_SF_SLL4:
      begin
        low_sh = {src[27:0], 4'h0};
        result = {{4{low_sh[31]}}, low_sh};
      end
      `SFB_SF_SLL8:
      begin
        low_sh = {src[23:0], 8'h00};
        result = {{4{low_sh[31]}}, low_sh};
      end
      `SFB_SF_SLL16:
      begin
        low_sh = {src[15:0], 16'h0000};
        result = {{4{low_sh[31]}}, low_sh};
      end
      // [RQ8] copy and negate
      `SFB_SF_COPY:  result = src;
      `SFB_SF_NEG:   result = (~src) + `SFB_INC_VAL;
      // [RQ9] round to upper 20 bits
      `SFB_SF_RND:   result = {rnd_sum[35:16], 16'h0000};
      // [RQ10] high half increment
      `SFB_SF_INCH:  result = {(src[35:16] + 20'h00001), 16'h0000};
      // [RQ11] full increment
      `SFB_SF_INC:   result = src + `SFB_INC_VAL;
      // [RQ12] y and aligned product copies
      `SFB_SF_Y:     result = {{4{y_val[31]}}, y_val};
      `SFB_SF_P:     result = p_val;
      default:       result = src;
    endcase
  end
endmodule // sfb_shifter

// *** tb/sfb_unit_asserts.sv ***
`timescale 1ns/1ps
`include "sfb_consts.vh"
module sfb_unit_asserts (
  input wire        clock,
  input wire        rst_b,
  input wire        sf_valid,
  input wire [3:0]  sf_op,
  input wire        sf_cond_en,
  input wire        sf_counted,
  input wire        ct_valid,
  input wire [2:0]  ct_op,
  input wire        ct_cond_en,
  input wire        in_cache,
  input wire        busy,
  input wire        ct_refused,
  input wire        flag_lvs,
  input wire [15:0] instruction_pointer,
  input wire [15:0] subroutine_return_reg,
  input wire [15:0] count_zero_reg,
  input wire [15:0] count_one_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Accepted control and whether it is the three-cycle kind
  wire take = ct_valid && !in_cache && !busy;
  wire slow = (ct_op == `SFB_CT_ICALL) || (ct_cond_en && ct_op != `SFB_CT_IRETURN);
  a_sf_ptr_step:
  assert property (sf_valid && !busy |=>
    instruction_pointer == $past(instruction_pointer) + 16'h0001) else $error("pointer step");
  a_uncond_time:
  assert property (take && !slow |=> busy ##1 !busy) else $error("uncond control length");
  a_cond_time:
  assert property (take && slow |=> busy [*2] ##1 !busy) else $error("cond control length");
  a_cache_refuse:
  assert property (ct_valid && in_cache && !busy |=> ct_refused && !busy)
    else $error("cached control not refused");
  a_refuse_cause:
  assert property (ct_refused |-> $past(ct_valid) && $past(in_cache)) else $error("stray refusal");
  a_zero_hold:
  assert property (sf_valid && sf_counted |=> $stable(count_zero_reg))
    else $error("counter zero moved");
  a_one_once:
  assert property (sf_valid && sf_counted |=>
    count_one_reg[7:0] == $past(count_one_reg[7:0]) + 8'h01) else $error("counter one bump");
  a_cnt_sext:
  assert property (count_one_reg[15:8] == {8{count_one_reg[7]}})
    else $error("counter one extension");
  a_lvs_clear:
  assert property (sf_valid && !sf_cond_en && sf_op != `SFB_SF_NOP |=> !flag_lvs)
    else $error("lvs kept");
  a_goto_keep:
  assert property (take && (ct_op == `SFB_CT_GOTO_IMM || ct_op == `SFB_CT_GOTO_TGT) |=>
    $stable(subroutine_return_reg) [*3]) else $error("jump touched return");
endmodule // sfb_unit_asserts
bind sfb_unit sfb_unit_asserts i_chk (.clock, .rst_b, .sf_valid, .sf_op, .sf_cond_en,
  .sf_counted, .ct_valid, .ct_op, .ct_cond_en, .in_cache, .busy, .ct_refused, .flag_lvs,
  .instruction_pointer, .subroutine_return_reg, .count_zero_reg, .count_one_reg);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "sfb_consts.vh"
module testbench;
  reg         clock = 1'b0;
  reg         rst_b = 1'b0;
  reg         sf_valid, sf_dst, sf_src, sf_cond_en, sf_counted, ct_valid, ct_cond_en;
  reg         in_cache, cond_invert, alu_valid, alu_dst, alu_lvs, alu_mvs, tgt_load;
  reg  [3:0]  sf_op;
  reg  [2:0]  ct_op;
  reg  [11:0] jump_target_field;
  reg  [4:0]  branch_predicate_field;
  reg  [35:0] alu_result, p_val;
  reg  [15:0] tgt_data;
  reg  [31:0] y_val;
  wire [35:0] first_accumulator, second_accumulator;
  wire [15:0] instruction_pointer, subroutine_return_reg, branch_target_reg;
  wire [15:0] interrupt_return_reg, count_zero_reg, count_one_reg, count_two_reg;
  wire        flag_n, flag_z, flag_lvs, flag_mvs, busy, ct_refused;
  // Bench model of the architectural state
  reg  [35:0] acc [0:1] = '{36'h0, 36'h0};
  reg  [15:0] pc = 16'h0, sr = 16'h0, pi = 16'h0, tgt = 16'h0;
  reg  [7:0]  k1 = 8'h00, k2 = 8'h00;
  reg         fn = 1'b0, fz = 1'b1, sf_seen = 1'b0, busy_q = 1'b0;
  reg  [31:0] seed = 21583, r;
  logic [39:0] notes [$], nt;
  integer     miscompares = 0, samples_checked = 0, cycles = 0, i;
  // Control table: op, conditional, code, invert
  localparam logic [9:0] CTS [0:10] = '{{`SFB_CT_GOTO_TGT, 1'b0, `SFB_CC_TRUE, 1'b0},
    {`SFB_CT_GOTO_IMM, 1'b0, `SFB_CC_TRUE, 1'b0}, {`SFB_CT_CALL_IMM, 1'b0, `SFB_CC_TRUE, 1'b0},
    {`SFB_CT_RETURN, 1'b0, `SFB_CC_TRUE, 1'b0}, {`SFB_CT_CALL_TGT, 1'b0, `SFB_CC_TRUE, 1'b0},
    {`SFB_CT_GOTO_IMM, 1'b1, `SFB_CC_TRUE, 1'b0}, {`SFB_CT_CALL_IMM, 1'b1, `SFB_CC_FALSE, 1'b1},
    {`SFB_CT_GOTO_TGT, 1'b1, `SFB_CC_TRUE, 1'b1}, {`SFB_CT_CALL_TGT, 1'b1, `SFB_CC_FALSE, 1'b0},
    {`SFB_CT_ICALL, 1'b1, `SFB_CC_FALSE, 1'b0}, {`SFB_CT_IRETURN, 1'b1, `SFB_CC_FALSE, 1'b0}};
  // Nominal sequencer timing only; stalls are left unexercised
  sfb_unit i_dut (.clock, .rst_b, .sf_valid, .sf_op, .sf_dst, .sf_src, .sf_cond_en,
    .sf_counted, .ct_valid, .ct_op, .ct_cond_en, .jump_target_field, .in_cache,
    .branch_predicate_field, .cond_invert, .alu_valid, .alu_dst, .alu_result, .alu_lvs,
    .alu_mvs, .tgt_load, .tgt_data, .y_val, .p_val, .seq_advance(1'b1), .first_accumulator,
    .second_accumulator, .instruction_pointer, .subroutine_return_reg, .branch_target_reg,
    .interrupt_return_reg, .count_zero_reg, .count_one_reg, .count_two_reg, .flag_n, .flag_z,
    .flag_lvs, .flag_mvs, .busy, .ct_refused);
  ////////////////////////////////////////////////////////////////////////////////
  always #50 clock = ~clock;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // One in four values is zero so the equal conditions get hit
  function logic [35:0] r36();
    logic [63:0] w;
    w = {xs(), xs()};
    return (w[63:62] == 2'h0) ? 36'h0 : w[35:0];
  endfunction
  function logic [35:0] sf_exp(input [3:0] op, input [35:0] s, input [31:0] y, input [35:0] p);
    integer k;
    logic [31:0] l;
    k = (op[1:0] == 2'h0) ? 1 : (op[1:0] == 2'h1) ? 4 : (op[1:0] == 2'h2) ? 8 : 16;
    l = s[31:0] << k;
    if (op < 4'h4) return $signed(s) >>> k;
    if (op < 4'h8) return {{4{l[31]}}, l};
    case (op)
      `SFB_SF_COPY: return s;
      `SFB_SF_NEG: return -s;
      `SFB_SF_RND: return (s + 36'h000008000) & 36'hFFFFF0000;
      `SFB_SF_INCH: return (s + 36'h000010000) & 36'hFFFFF0000;
      `SFB_SF_INC: return s + 36'h000000001;
      `SFB_SF_Y: return {{4{y[31]}}, y};
      default: return p;
    endcase
  endfunction
  function logic cond(input [4:0] cc);
    case (cc)
      `SFB_CC_NEG: return fn;
      `SFB_CC_POS: return !fn;
      `SFB_CC_EQ: return fz;
      `SFB_CC_NE: return !fz;
      `SFB_CC_GT: return !fn && !fz;
      `SFB_CC_LE: return fn || fz;
      `SFB_CC_TRUE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function logic [35:0] pick(input [2:0] k);
    case (k)
      3'h0: return first_accumulator;
      3'h1: return second_accumulator;
      3'h2: return {20'h0, instruction_pointer};
      3'h3: return {20'h0, subroutine_return_reg};
      3'h4: return {20'h0, count_one_reg};
      3'h5: return {20'h0, count_two_reg};
      3'h6: return {20'h0, interrupt_return_reg};
      default: return {34'h0, flag_n, flag_z};
    endcase
  endfunction
  task note(input lst, input [2:0] k, input [35:0] v);
    notes.push_back({lst, k, v});
  endtask
  task check(input [35:0] seen, input [35:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Special op: model update at issue, results noted for the monitor
  task sf(input [3:0] op, input d, input s, input ce, input cn, input [4:0] cc, input inv);
    logic [31:0] yv;
    logic [35:0] pv, v;
    logic ex;
    yv = xs();
    pv = r36();
    ex = (op != `SFB_SF_NOP) && (!ce || (cond(cc) ^ inv));
    v = ex ? sf_exp(op, acc[s], yv, pv) : acc[d];
    @(posedge clock);
    {sf_valid, alu_valid, ct_valid, tgt_load} <= 4'h8;
    {sf_op, sf_dst, sf_src, sf_cond_en, sf_counted} <= {op, d, s, ce, cn};
    {branch_predicate_field, cond_invert, y_val, p_val} <= {cc, inv, yv, pv};
    acc[d] = v;
    pc = pc + 16'h0001;
    // Interrupt return shadows the advancing pointer
    pi = pc;
    if (ex) {fn, fz} = {v[35], v == 36'h0};
    // counter one bump, copy to two
    if (cn) k1 = k1 + 8'h01;
    if (cn && ex) k2 = k1;
    note(1'b0, {2'h0, d}, v);
    note(1'b0, 3'h7, {34'h0, fn, fz});
    if (cn) note(1'b0, 3'h4, {20'h0, {8{k1[7]}}, k1});
    if (cn && cc >= `SFB_CC_TRUE) note(1'b0, 3'h5, {20'h0, {8{k2[7]}}, k2});
    note(1'b1, 3'h2, {20'h0, pc});
  endtask
  task alu(input d, input [35:0] v);
    logic [31:0] q;
    q = xs();
    @(posedge clock);
    {sf_valid, alu_valid, ct_valid, tgt_load} <= 4'h4;
    {alu_dst, alu_result, alu_lvs, alu_mvs} <= {d, v, q[1:0]};
    acc[d] = v;
    pc = pc + 16'h0001;
    pi = pc;
    {fn, fz} = {v[35], v == 36'h0};
  endtask
  task ptl(input [15:0] v);
    @(posedge clock);
    {sf_valid, alu_valid, ct_valid, tgt_load} <= 4'h1;
    tgt_data <= v;
    tgt = v;
  endtask
  // Control op: wait on busy under a bound, refused ones leave no notes
  task ct(input [2:0] op, input ce, input [4:0] cc, input inv, input cache);
    logic [31:0] q;
    logic tk;
    integer n;
    q = xs();
    tk = op == `SFB_CT_ICALL || op == `SFB_CT_IRETURN || !ce || (cond(cc) ^ inv);
    @(posedge clock);
    {sf_valid, alu_valid, ct_valid, tgt_load} <= 4'h2;
    {ct_op, ct_cond_en, branch_predicate_field, cond_invert} <= {op, ce, cc, inv};
    {jump_target_field, in_cache} <= {q[11:0], cache};
    if (!cache)
    begin
      if (tk && (op == `SFB_CT_CALL_IMM || op == `SFB_CT_CALL_TGT)) sr = pc + (ce ? 16'h2 : 16'h1);
      if (!tk) pc = pc + 16'h0002;
      else if (op == `SFB_CT_GOTO_IMM || op == `SFB_CT_CALL_IMM) pc = {pc[15:12], q[11:0]};
      else if (op == `SFB_CT_GOTO_TGT || op == `SFB_CT_CALL_TGT) pc = tgt;
      else if (op == `SFB_CT_RETURN) pc = sr;
      else if (op == `SFB_CT_IRETURN) pc = pi;
      else {pi, pc} = {pc + 16'h0001, 16'h0002};
      note(1'b0, 3'h2, {20'h0, pc});
      note(1'b0, 3'h6, {20'h0, pi});
      note(1'b1, 3'h3, {20'h0, sr});
    end
    @(posedge clock);
    {ct_valid, in_cache} <= 2'h0;
    @(negedge clock);
    for (n = 0; n < 10 && busy !== 1'b0; n++) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Results are judged on the falling edge, once the launching edge has landed
  always @(posedge clock) sf_seen <= sf_valid;
  always @(negedge clock)
  begin
    if (sf_seen || (busy_q && busy === 1'b0))
      while (notes.size() > 0)
      begin
        nt = notes.pop_front();
        check(pick(nt[38:36]), nt[35:0]);
        if (nt[39]) break;
      end
    busy_q <= busy;
  end
  // Hang guard: a few thousand cycles is far above the planned run
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      miscompares = miscompares + 1;
      final_report();
    end
  end
  initial
  begin
    {sf_valid, sf_dst, sf_src, sf_cond_en, sf_counted, ct_valid, ct_cond_en} = 7'h00;
    {in_cache, cond_invert, alu_valid, alu_dst, alu_lvs, alu_mvs, tgt_load} = 7'h00;
    {sf_op, ct_op, jump_target_field, branch_predicate_field} = 24'h0;
    {alu_result, p_val, tgt_data, y_val} = 120'h0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    check(pick(3'h7), 36'h000000001);
    check(pick(3'h2), 36'h000000000);
    for (i = 0; i < 32; i++)
    begin
      r = xs();
      alu(r[0], r36());
      sf(i[3:0], r[1], r[2], 1'b0, 1'b0, `SFB_CC_TRUE, 1'b0);
    end
    $display("test special ops done");
    // flags from alu or special op
    for (i = 0; i < 48; i++)
    begin
      r = xs();
      alu(r[0], r36());
      if (r[5]) sf(r[7:4] == 4'hF ? 4'h9 : r[7:4], r[1], r[0], 1'b0, 1'b0, `SFB_CC_TRUE, 1'b0);
      sf(`SFB_SF_INC, r[2], r[3], 1'b1, 1'b0, 5'((i >> 1) % 6), i[0]);
    end
    $display("test conditions done");
    for (i = 0; i < 260; i++)
    begin
      r = xs();
      sf(`SFB_SF_COPY, r[0], r[1], 1'b1, 1'b1, r[2] ? `SFB_CC_TRUE : `SFB_CC_FALSE, r[3]);
    end
    // remaining codes on a self copy
    for (i = 6; i < 15; i++)
    begin
      sf(`SFB_SF_COPY, 1'b0, 1'b0, 1'b0, 1'b0, `SFB_CC_TRUE, 1'b0);
      sf(`SFB_SF_COPY, 1'b0, 1'b0, 1'b1, 1'b1, 5'(i), i[0]);
    end
    $display("test counters done");
    r = xs();
    ptl(r[15:0]);
    for (i = 0; i < 11; i++)
    begin
      ct(CTS[i][9:7], CTS[i][6], CTS[i][5:1], CTS[i][0], 1'b0);
      sf(`SFB_SF_NOP, 1'b0, 1'b1, 1'b0, 1'b0, `SFB_CC_TRUE, 1'b0);
    end
    ct(`SFB_CT_GOTO_IMM, 1'b0, `SFB_CC_TRUE, 1'b0, 1'b1);
    sf(`SFB_SF_NOP, 1'b1, 1'b0, 1'b0, 1'b0, `SFB_CC_TRUE, 1'b0);
    $display("test control done");
    @(posedge clock);
    {sf_valid, alu_valid, ct_valid, tgt_load} <= 4'h0;
    repeat (3) @(posedge clock);
    final_report();
  end
endmodule // testbench
